// ==== temp_sense_pkg.sv ====
// Shared constants, register map and state codes of the temperature monitor
package temp_sense_pkg;

   // Timebase: one millisecond tick derived from the 50 MHz clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_NS = 1_000_000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

   // Measurement cycle timing, in milliseconds
   localparam int BIAS_MS = 24;
   localparam int DEGLITCH_MS = 10;
   localparam int MON_PRIO_MS = 35;
   localparam int MON_STD_MS = 235;

   // End-power message code for an internal fault
   localparam logic [7:0] EPT_INTERNAL_FAULT = 8'h02;
   // Largest margin subtracted from the reported power, in mW
   localparam logic [15:0] MAX_MARGIN_MW = 16'h00FA;

   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_MASK = 12'h008;
   localparam logic [11:0] OFS_STATE = 12'h00C;
   localparam logic [11:0] OFS_MARGIN = 12'h010;
   localparam logic [11:0] OFS_POWER = 12'h014;

   // Control field positions
   localparam int CTRL_PRIO_BIT = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam int CTRL_AVG_LSB = 4;
   localparam int CTRL_AVG_W = 3;

   // Status and mask bit positions
   localparam int EV_HOT = 0;
   localparam int EV_COLD = 1;
   localparam int EV_EXT = 2;
   localparam int EV_FAULT = 3;
   localparam int EV_DONE = 4;
   localparam int EV_THERM = 5;
   localparam int EV_W = 6;

   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [EV_W-1:0] MASK_RESET = 6'h00;
   localparam logic [15:0] MARGIN_RESET = 16'h0000;

   // Shutdown reason codes
   localparam logic [1:0] WHY_NONE = 2'h0;
   localparam logic [1:0] WHY_FAULT = 2'h1;
   localparam logic [1:0] WHY_DONE = 2'h2;
   localparam logic [1:0] WHY_THERM = 2'h3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_BIAS = 3'b001,
      ST_MON = 3'b010,
      ST_OFF = 3'b100
   } mon_state_type;

endpackage

// ==== deglitch_filter.sv ====
// Comparator deglitch: output follows input after a steady run of ticks
module deglitch_filter #(
   parameter int TICKS = temp_sense_pkg::DEGLITCH_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic enable,
   input wire logic raw,
   output logic filtered
);

   initial begin
      if (TICKS < 1 || TICKS > 255) begin
         $error("deglitch_filter: TICKS out of range");
      end
   end

   logic [7:0] cnt_q, cnt_d;
   logic filt_q, filt_d;

   // Disagreement must last TICKS ticks; outside the window the result is held
   always_comb begin
      cnt_d = cnt_q;
      filt_d = filt_q;
      if (!enable || raw == filt_q) begin
         cnt_d = 8'h00;
      end else if (tick) begin
         if (cnt_q == 8'(TICKS - 1)) begin
            filt_d = raw;
            cnt_d = 8'h00;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 8'h00;
         filt_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         filt_q <= filt_d;
      end
   end

   assign filtered = filt_q;

   property p_filter_moves;
      @(posedge aclk) disable iff (!aresetn)
         (filt_q != $past(filt_q)) |-> $past(tick && enable && cnt_q == 8'(TICKS - 1));
   endproperty
   a_filter_moves: assert property (p_filter_moves) else $error("filter moved early");

endmodule

// ==== temp_sense_ctrl_monitor.sv ====
// Temperature sense, host control detection and power report block
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
module temp_sense_ctrl_monitor #(
   parameter int TICK_CYCLES = temp_sense_pkg::TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cmp_hot,
   input wire logic cmp_cold,
   input wire logic cmp_grounded,
   input wire logic cmp_ctrl_level,
   input wire logic die_over_temp,
   input wire logic [15:0] power_sample,
   input wire logic power_sample_valid,
   output logic temp_bias_window,
   output logic thermistor_bias_pin_o,
   output logic thermistor_bias_pin_oe,
   output logic regulator_enable,
   output logic [1:0] shutdown_reason,
   output logic ext_ctrl_detected,
   output logic ept_send,
   output logic [7:0] ept_code,
   output logic [15:0] rx_power_report,
   output logic rx_power_valid,
   output logic irq
);

   initial begin
      if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin
         $error("temp_sense_ctrl_monitor: TICK_CYCLES out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decoding and strobe helpers

   function automatic logic [2:0] reg_index(input logic [11:0] addr);
      case (addr)
         temp_sense_pkg::OFS_CTRL: reg_index = 3'h1;
         temp_sense_pkg::OFS_STATUS: reg_index = 3'h2;
         temp_sense_pkg::OFS_MASK: reg_index = 3'h3;
         temp_sense_pkg::OFS_STATE: reg_index = 3'h4;
         temp_sense_pkg::OFS_MARGIN: reg_index = 3'h5;
         temp_sense_pkg::OFS_POWER: reg_index = 3'h6;
         default: reg_index = 3'h0;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Millisecond timebase and comparator filters

   logic [15:0] div_q, div_d;
   logic tick_q, tick_d;

   // Divider pulse keeps every slow count on the one clock
   always_comb begin
      tick_d = 1'b0;
      div_d = div_q + 16'h0001;
      if (div_q == 16'(TICK_CYCLES - 1)) begin
         div_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   temp_sense_pkg::mon_state_type state_q, state_d;
   logic [2:0] cmp_raw, cmp_filt;
   assign cmp_raw = {cmp_grounded, cmp_cold, cmp_hot};

   // Comparators are only meaningful while the divider is biased
   for (genvar g = 0; g < 3; g++) begin : g_filt
      deglitch_filter #(
         .TICKS(temp_sense_pkg::DEGLITCH_MS)
      ) u_filt (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick(tick_q),
         .enable(state_q == temp_sense_pkg::ST_BIAS),
         .raw(cmp_raw[g]),
         .filtered(cmp_filt[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers, sequencer, power averaging and bus slave

   logic [7:0] ms_q, ms_d;
   logic prio_q, prio_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic [temp_sense_pkg::EV_W-1:0] status_q, status_d, mask_q, mask_d, ev;
   logic [15:0] margin_q, margin_d;
   logic [1:0] why_q, why_d;
   logic ext_q, ext_d, ept_q, ept_d, irq_q, irq_d, bias_q, bias_d, reg_q, reg_d;
   logic [2:0] hc_prev_q, hc_prev_d;
   logic [23:0] acc_q, acc_d;
   logic [7:0] nsamp_q, nsamp_d;
   logic [15:0] rpt_q, rpt_d;
   logic rptv_q, rptv_d;
   logic aw_q, aw_d, w_q, w_d, awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
   logic arr_q, arr_d, rv_q, rv_d;
   logic [11:0] awa_q, awa_d;
   logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;
   logic [3:0] wstb_q, wstb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

   always_comb begin
      logic [2:0] widx;
      logic [31:0] wv;
      logic restart;
      logic [23:0] acc_n;
      logic [15:0] avg;
      logic [2:0] lg;
      logic [7:0] last;
      widx = 3'h0;
      wv = 32'h0000_0000;
      restart = 1'b0;
      acc_n = 24'h000000;
      avg = 16'h0000;
      lg = 3'h0;
      last = 8'h00;
      state_d = state_q;
      ms_d = ms_q;
      prio_d = prio_q;
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      margin_d = margin_q;
      why_d = why_q;
      ext_d = ext_q;
      ept_d = 1'b0;
      ev = '0;
      hc_prev_d = cmp_filt;
      acc_d = acc_q;
      nsamp_d = nsamp_q;
      rpt_d = rpt_q;
      rptv_d = 1'b0;
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wdat_d = wdat_q;
      wstb_d = wstb_q;
      bv_d = bv_q;
      bresp_d = bresp_q;
      rv_d = rv_q;
      rdat_d = rdat_q;
      rresp_d = rresp_q;
      status_d = status_q;

      // Write address and data are caught in either order
      if (s_axi_awvalid && awr_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wr_q) begin
         w_d = 1'b1;
         wdat_d = s_axi_wdata;
         wstb_d = s_axi_wstrb;
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (aw_q && w_q && !bv_q) begin
         widx = reg_index(awa_q);
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         bresp_d = temp_sense_pkg::RESP_OKAY;
         case (widx)
            3'h1: begin
               wv = merge(ctrl_q, wdat_q, wstb_q);
               restart = wv[temp_sense_pkg::CTRL_RESTART_BIT];
               ctrl_d = wv & ~(32'h1 << temp_sense_pkg::CTRL_RESTART_BIT);
            end
            3'h2: wv = merge(32'h0, wdat_q, wstb_q);
            3'h3: begin
               wv = merge({26'h0, mask_q}, wdat_q, wstb_q);
               mask_d = wv[temp_sense_pkg::EV_W-1:0];
            end
            3'h5: begin
               wv = merge({16'h0, margin_q}, wdat_q, wstb_q);
               // Margin capped so the report never drops too far below
               margin_d = (wv[15:0] > temp_sense_pkg::MAX_MARGIN_MW) ?
                          temp_sense_pkg::MAX_MARGIN_MW : wv[15:0];
            end
            3'h4, 3'h6: ;
            default: bresp_d = temp_sense_pkg::RESP_SLVERR;
         endcase
      end
      awr_d = !aw_d && !(aw_q && w_q);
      wr_d = !w_d && !(aw_q && w_q);

      // Read answers one cycle after the address is taken
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      if (s_axi_arvalid && arr_q) begin
         rv_d = 1'b1;
         rresp_d = temp_sense_pkg::RESP_OKAY;
         case (reg_index(s_axi_araddr))
            3'h1: rdat_d = ctrl_q;
            3'h2: rdat_d = {26'h0, status_q};
            3'h3: rdat_d = {26'h0, mask_q};
            3'h4: rdat_d = {22'h0, why_q, 1'b0, state_q, reg_q, cmp_filt[1:0],
                            bias_q};
            3'h5: rdat_d = {16'h0, margin_q};
            3'h6: rdat_d = {16'h0, rpt_q};
            default: begin
               rdat_d = 32'h0000_0000;
               rresp_d = temp_sense_pkg::RESP_SLVERR;
            end
         endcase
      end
      arr_d = !rv_d;

      // Filtered hot or cold crossings raise events and idle the regulator
      ev[temp_sense_pkg::EV_HOT] = cmp_filt[0] && !hc_prev_q[0];
      ev[temp_sense_pkg::EV_COLD] = cmp_filt[1] && !hc_prev_q[1];

      // Measurement sequencer: bias window, unbiased watch, repeat
      case (state_q)
         temp_sense_pkg::ST_BIAS: begin
            if (tick_q) begin
               ms_d = ms_q + 8'h01;
               if (ms_q == 8'(temp_sense_pkg::BIAS_MS - 1)) begin
                  state_d = temp_sense_pkg::ST_MON;
                  ms_d = 8'h00;
                  prio_d = ctrl_q[temp_sense_pkg::CTRL_PRIO_BIT];
               end
            end
            // Held filter output alone is stale after a restart
            if (cmp_filt[2] && cmp_grounded) begin
               state_d = temp_sense_pkg::ST_OFF;
               why_d = temp_sense_pkg::WHY_FAULT;
               ev[temp_sense_pkg::EV_FAULT] = 1'b1;
            end
         end
         temp_sense_pkg::ST_MON: begin
            if (tick_q) begin
               ms_d = ms_q + 8'h01;
               if (ms_q == 8'((prio_q ? temp_sense_pkg::MON_PRIO_MS :
                               temp_sense_pkg::MON_STD_MS) - 1)) begin
                  state_d = temp_sense_pkg::ST_BIAS;
                  ms_d = 8'h00;
               end
            end
            if (cmp_ctrl_level) begin
               ext_d = 1'b1;
               ev[temp_sense_pkg::EV_EXT] = 1'b1;
               ev[temp_sense_pkg::EV_DONE] = 1'b1;
               state_d = temp_sense_pkg::ST_OFF;
               why_d = temp_sense_pkg::WHY_DONE;
            end
         end
         temp_sense_pkg::ST_OFF: begin
            ms_d = 8'h00;
            if (restart) begin
               state_d = temp_sense_pkg::ST_BIAS;
               why_d = temp_sense_pkg::WHY_NONE;
               ext_d = 1'b0;
            end
         end
         default: begin
            state_d = temp_sense_pkg::ST_OFF;
            ms_d = 8'h00;
         end
      endcase

      // Die overheat overrides every other shutdown reason
      if (die_over_temp) begin
         state_d = temp_sense_pkg::ST_OFF;
         why_d = temp_sense_pkg::WHY_THERM;
         ev[temp_sense_pkg::EV_THERM] = (why_q != temp_sense_pkg::WHY_THERM);
         ept_d = (why_q != temp_sense_pkg::WHY_THERM);
      end

      bias_d = (state_d == temp_sense_pkg::ST_BIAS);
      reg_d = (state_d != temp_sense_pkg::ST_OFF) && !cmp_filt[0] && !cmp_filt[1];

      // New events win over a same-cycle write-one-to-clear
      status_d = (status_q & ~wv[temp_sense_pkg::EV_W-1:0] &
                  {temp_sense_pkg::EV_W{widx == 3'h2}}) |
                 (status_q & {temp_sense_pkg::EV_W{widx != 3'h2}}) | ev;
      irq_d = |(status_d & mask_d);

      // Averaging over 2^n samples keeps the divide a plain shift
      lg = ctrl_q[temp_sense_pkg::CTRL_AVG_LSB +: temp_sense_pkg::CTRL_AVG_W];
      last = 8'((9'd1 << lg) - 9'd1);
      if (power_sample_valid) begin
         acc_n = acc_q + {8'h00, power_sample};
         if (nsamp_q >= last) begin
            avg = 16'(acc_n >> lg);
            rpt_d = (avg > margin_q) ? (avg - margin_q) : 16'h0000;
            rptv_d = 1'b1;
            acc_d = 24'h000000;
            nsamp_d = 8'h00;
         end else begin
            acc_d = acc_n;
            nsamp_d = nsamp_q + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= temp_sense_pkg::ST_BIAS;
         ms_q <= 8'h00;
         prio_q <= 1'b0;
         ctrl_q <= temp_sense_pkg::CTRL_RESET;
         status_q <= '0;
         mask_q <= temp_sense_pkg::MASK_RESET;
         margin_q <= temp_sense_pkg::MARGIN_RESET;
         why_q <= temp_sense_pkg::WHY_NONE;
         ext_q <= 1'b0;
         ept_q <= 1'b0;
         irq_q <= 1'b0;
         bias_q <= 1'b0;
         reg_q <= 1'b0;
         hc_prev_q <= 3'h0;
         acc_q <= 24'h000000;
         nsamp_q <= 8'h00;
         rpt_q <= 16'h0000;
         rptv_q <= 1'b0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awr_q <= 1'b0;
         wr_q <= 1'b0;
         bv_q <= 1'b0;
         arr_q <= 1'b0;
         rv_q <= 1'b0;
         awa_q <= 12'h000;
         wdat_q <= 32'h0000_0000;
         wstb_q <= 4'h0;
         rdat_q <= 32'h0000_0000;
         bresp_q <= 2'h0;
         rresp_q <= 2'h0;
      end else begin
         state_q <= state_d;
         ms_q <= ms_d;
         prio_q <= prio_d;
         ctrl_q <= ctrl_d;
         status_q <= status_d;
         mask_q <= mask_d;
         margin_q <= margin_d;
         why_q <= why_d;
         ext_q <= ext_d;
         ept_q <= ept_d;
         irq_q <= irq_d;
         bias_q <= bias_d;
         reg_q <= reg_d;
         hc_prev_q <= hc_prev_d;
         acc_q <= acc_d;
         nsamp_q <= nsamp_d;
         rpt_q <= rpt_d;
         rptv_q <= rptv_d;
         aw_q <= aw_d;
         w_q <= w_d;
         awr_q <= awr_d;
         wr_q <= wr_d;
         bv_q <= bv_d;
         arr_q <= arr_d;
         rv_q <= rv_d;
         awa_q <= awa_d;
         wdat_q <= wdat_d;
         wstb_q <= wstb_d;
         rdat_q <= rdat_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
      end
   end

   // Output wiring, all straight from flops except the constant ept_code
   assign s_axi_awready = awr_q;
   assign s_axi_wready = wr_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rdat_q;
   assign s_axi_rresp = rresp_q;
   assign temp_bias_window = bias_q;
   assign thermistor_bias_pin_o = bias_q;
   assign thermistor_bias_pin_oe = bias_q;
   assign regulator_enable = reg_q;
   assign shutdown_reason = why_q;
   assign ext_ctrl_detected = ext_q;
   assign ept_send = ept_q;
   assign ept_code = temp_sense_pkg::EPT_INTERNAL_FAULT;
   assign rx_power_report = rpt_q;
   assign rx_power_valid = rptv_q;
   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_bias_len;
      @(posedge aclk) disable iff (!aresetn)
         $fell(bias_q) && state_q == temp_sense_pkg::ST_MON |->
            $past(ms_q) == 8'(temp_sense_pkg::BIAS_MS - 1) && $past(tick_q);
   endproperty
   a_bias_len: assert property (p_bias_len) else $error("bias window wrong length");

   property p_float_after;
      @(posedge aclk) disable iff (!aresetn)
         state_q == temp_sense_pkg::ST_MON |-> !thermistor_bias_pin_oe ##1 !bias_q || ms_q == 0;
   endproperty
   a_float_after: assert property (p_float_after) else $error("bias pin driven in watch");

   property p_ext_detect;
      @(posedge aclk) disable iff (!aresetn)
         state_q == temp_sense_pkg::ST_MON && cmp_ctrl_level |=> ext_q && !reg_q;
   endproperty
   a_ext_detect: assert property (p_ext_detect) else $error("external drive missed");

   property p_ext_source;
      @(posedge aclk) disable iff (!aresetn)
         $rose(ext_q) |-> $past(state_q) == temp_sense_pkg::ST_MON;
   endproperty
   a_ext_source: assert property (p_ext_source) else $error("detect outside watch");

   property p_done_reason;
      @(posedge aclk) disable iff (!aresetn)
         state_q == temp_sense_pkg::ST_MON && cmp_ctrl_level && !die_over_temp |=>
            why_q == temp_sense_pkg::WHY_DONE;
   endproperty
   a_done_reason: assert property (p_done_reason) else $error("done reason wrong");

   property p_fault_reason;
      @(posedge aclk) disable iff (!aresetn)
         state_q == temp_sense_pkg::ST_BIAS && cmp_filt[2] && cmp_grounded && !die_over_temp |=>
            why_q == temp_sense_pkg::WHY_FAULT && !reg_q;
   endproperty
   a_fault_reason: assert property (p_fault_reason) else $error("fault not shut down");

   property p_thermal;
      @(posedge aclk) disable iff (!aresetn)
         die_over_temp |=> !regulator_enable && why_q == temp_sense_pkg::WHY_THERM;
   endproperty
   a_thermal: assert property (p_thermal) else $error("overheat left regulator on");

   property p_ept;
      @(posedge aclk) disable iff (!aresetn)
         ept_q |-> ept_code == 8'h02 && !reg_q ##1 !ept_q;
   endproperty
   a_ept: assert property (p_ept) else $error("end-power message malformed");

   property p_hot_event;
      @(posedge aclk) disable iff (!aresetn)
         $rose(cmp_filt[0]) |=> status_q[temp_sense_pkg::EV_HOT] && !reg_q;
   endproperty
   a_hot_event: assert property (p_hot_event) else $error("hot crossing ignored");

   property p_repeat;
      @(posedge aclk) disable iff (!aresetn)
         state_q == temp_sense_pkg::ST_MON && tick_q && !cmp_ctrl_level && !die_over_temp &&
         ms_q == 8'((prio_q ? temp_sense_pkg::MON_PRIO_MS : temp_sense_pkg::MON_STD_MS) - 1)
         |=> state_q == temp_sense_pkg::ST_BIAS && bias_q;
   endproperty
   a_repeat: assert property (p_repeat) else $error("cycle did not repeat");

   property p_report_margin;
      @(posedge aclk) disable iff (!aresetn)
         rptv_q |-> margin_q <= 16'h00FA;
   endproperty
   a_report_margin: assert property (p_report_margin) else $error("margin too large");

endmodule

// ==== host_model.sv ====
// Host controller driving the shared pin through a three-state network
module host_model (
   input wire logic [1:0] mode,
   output logic cmp_grounded,
   output logic cmp_ctrl_level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic term;
   logic fault;
   // Mode 0 idles with term high and fault low, so the pin floats
   assign term = (mode != 2'h1);
   assign fault = (mode == 2'h2);
   // Fault grounds the pin, term low pulls it up to the battery
   assign cmp_grounded = term & fault;
   assign cmp_ctrl_level = !term & !fault;
endmodule

// ==== temp_sense_ctrl_monitor_test.sv ====
// Self-checking bench for the temperature monitor
module temp_sense_ctrl_monitor_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int L = 2000;
   localparam int TK = 4;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, cmp_hot = 0, cmp_cold = 0;
   logic die_over_temp = 0, power_sample_valid = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [15:0] power_sample = 0, rx_power_report;
   logic [1:0] mode = 0, s_axi_bresp, s_axi_rresp, shutdown_reason, r;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic cmp_grounded, cmp_ctrl_level, temp_bias_window, thermistor_bias_pin_o;
   logic thermistor_bias_pin_oe, regulator_enable, ext_ctrl_detected, ept_send;
   logic rx_power_valid, irq;
   logic [7:0] ept_code;
   int fails = 0, comparisons = 0, n;
   temp_sense_ctrl_monitor #(.TICK_CYCLES(TK)) dut_u (.*);
   host_model host_u (.*);
   initial forever #10 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   task chk(string s, logic [31:0] v, logic [31:0] e);
      comparisons++;
      if (v !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, v);
      end
   endtask
   task summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // A used-up bound counts as a mismatch and ends the run
   task tmo(int k);
      if (k >= L) begin
         fails++;
         summarize;
      end
   endtask
   task cyc(int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic wt(ref logic s, input logic v);
      int k;
      for (k = 0; k < L && s !== v; k++) @(posedge aclk);
      tmo(k);
   endtask
   task automatic len(ref logic s, input logic v, output int k);
      for (k = 0; k < L && s === v; k++) @(posedge aclk);
      tmo(k);
   endtask
   // Each channel released only at the edge its ready is seen
   // Response ready stays high between writes, and every call sets it high again
   task wr(logic [11:0] a, logic [31:0] v);
      int k;
      logic aw, w;
      aw = 1;
      w = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (k = 0; k < L; k++) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 0;
            s_axi_awvalid <= 0;
         end
         if (w && s_axi_wready) begin
            w = 0;
            s_axi_wvalid <= 0;
         end
         if (!aw && !w && s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      tmo(k);
   endtask
   task rd(logic [11:0] a);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (k = 0; k < L && s_axi_rvalid !== 1; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      tmo(k);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Short hot blip is swallowed, held hot and cold readings cut the regulator
   task s_temp;
      cmp_hot <= 1;
      cyc(4 * TK);
      cmp_hot <= 0;
      cyc(2 * TK);
      chk("reg_blip", regulator_enable, 1);
      cmp_hot <= 1;
      cmp_cold <= 1;
      cyc(12 * TK);
      chk("reg_cold", regulator_enable, 0);
      rd(temp_sense_pkg::OFS_STATUS);
      chk("st_hot_cold", d[1:0], 2'h3);
      cmp_hot <= 0;
      cmp_cold <= 0;
   endtask
   // Window lengths in both periods; tick phase gives up to one tick of slack
   task s_win;
      wr(temp_sense_pkg::OFS_CTRL, 32'h0000_0001);
      wt(temp_bias_window, 0);
      cyc(1);
      chk("oe_off", thermistor_bias_pin_oe, 0);
      len(temp_bias_window, 0, n);
      chk("watch_prio", n >= 35 * TK - TK && n <= 35 * TK + TK, 1);
      chk("pin_on", {thermistor_bias_pin_o, thermistor_bias_pin_oe}, 2'h3);
      wr(temp_sense_pkg::OFS_CTRL, 32'h0000_0000);
      wt(temp_bias_window, 0);
      len(temp_bias_window, 0, n);
      chk("watch", n >= 235 * TK - TK && n <= 235 * TK + TK, 1);
      len(temp_bias_window, 1, n);
      chk("bias", n >= 24 * TK - TK && n <= 24 * TK + TK, 1);
   endtask
   task s_done;
      wr(temp_sense_pkg::OFS_MASK, 32'h0000_0010);
      wr(temp_sense_pkg::OFS_STATUS, 32'h0000_003F);
      wt(temp_bias_window, 0);
      mode <= 2'h1;
      wt(ext_ctrl_detected, 1);
      cyc(2);
      chk("why_done", shutdown_reason, temp_sense_pkg::WHY_DONE);
      chk("reg_done", regulator_enable, 0);
      chk("irq_on", irq, 1);
      rd(temp_sense_pkg::OFS_STATUS);
      chk("st_ext", d[temp_sense_pkg::EV_EXT], 1);
      mode <= 2'h0;
      wr(temp_sense_pkg::OFS_STATUS, 32'h0000_003F);
      cyc(2);
      chk("irq_off", irq, 0);
      wr(temp_sense_pkg::OFS_CTRL, 32'h0000_0002);
      cyc(2);
      chk("why_none", shutdown_reason, temp_sense_pkg::WHY_NONE);
   endtask
   // Restart opens a bias window; grounding must outlast the filter
   task s_fault;
      mode <= 2'h2;
      cyc(15 * TK);
      chk("why_fault", shutdown_reason, temp_sense_pkg::WHY_FAULT);
      mode <= 2'h0;
      wr(temp_sense_pkg::OFS_CTRL, 32'h0000_0002);
   endtask
   task s_therm;
      die_over_temp <= 1;
      wt(ept_send, 1);
      chk("code", ept_code, 8'h02);
      cyc(2);
      chk("ept_once", ept_send, 0);
      chk("why_th", shutdown_reason, temp_sense_pkg::WHY_THERM);
      chk("reg_th", regulator_enable, 0);
      die_over_temp <= 0;
      wr(temp_sense_pkg::OFS_CTRL, 32'h0000_0002);
   endtask
   task s_pwr;
      wr(temp_sense_pkg::OFS_MARGIN, 32'h0000_012C);
      chk("wr_okay", r, temp_sense_pkg::RESP_OKAY);
      rd(temp_sense_pkg::OFS_MARGIN);
      chk("margin", d, 32'h0000_00FA);
      power_sample <= 16'h03E8;
      power_sample_valid <= 1;
      cyc(1);
      power_sample_valid <= 0;
      wt(rx_power_valid, 1);
      chk("report", rx_power_report, 16'h02EE);
      cyc(1);
      chk("valid_pulse", rx_power_valid, 0);
      // Two samples of 1000 and 1200 mW averaged, less the capped margin
      wr(temp_sense_pkg::OFS_CTRL, 32'h0000_0010);
      power_sample <= 16'h03E8;
      power_sample_valid <= 1;
      cyc(1);
      power_sample <= 16'h04B0;
      cyc(1);
      power_sample_valid <= 0;
      wt(rx_power_valid, 1);
      chk("average", rx_power_report, 16'h0352);
      rd(12'hFF0);
      chk("unmapped", r, temp_sense_pkg::RESP_SLVERR);
      wr(12'hFF0, 32'h0000_0000);
      chk("wr_unmapped", r, temp_sense_pkg::RESP_SLVERR);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(4);
      aresetn <= 1;
      cyc(2);
      s_temp;
      s_win;
      s_done;
      s_fault;
      s_therm;
      s_pwr;
      summarize;
   end
endmodule
